// >>> pst_pkg.sv
// constants and types for the event-clear and self-test block
package pst_pkg;

   // management register offsets
   localparam logic [4:0] PST_REG_EVT_CLR   = 5'h17;
   localparam logic [4:0] PST_REG_CNT_WIN   = 5'h18;
   localparam logic [4:0] PST_REG_CFG_A     = 5'h19;
   localparam logic [4:0] PST_REG_CFG_B     = 5'h1a;

   // management frame codes and lengths
   localparam logic [1:0] PST_OP_READ       = 2'h2;
   localparam logic [1:0] PST_OP_WRITE      = 2'h1;
   localparam int         PST_PRE_BITS      = 32;
   localparam int         PST_HDR_BITS      = 12;
   localparam int         PST_DATA_BITS     = 16;

   // event clear register layout
   localparam int         PST_EVT_LO        = 3;
   localparam int         PST_EVT_HI        = 15;

   // config a layout
   localparam int         PST_A_CNT_TYPE    = 15;
   localparam int         PST_A_CNT_CLR     = 14;
   localparam int         PST_A_LONG_LEN    = 13;
   localparam int         PST_A_LONG_IFG    = 12;
   localparam int         PST_A_TX_EN       = 11;
   localparam int         PST_A_PRBS        = 10;
   localparam int         PST_A_PAT_HI      = 7;

   // config b layout
   localparam int         PST_B_RX_EN       = 15;
   localparam int         PST_B_HALF        = 14;
   localparam int         PST_B_CNT_HI      = 13;
   localparam int         PST_B_CNT_LO      = 11;
   localparam int         PST_B_LINK_SEL    = 0;

   // frame lengths in bytes
   localparam logic [10:0] PST_LEN_LONG     = 11'h5ea;
   localparam logic [10:0] PST_LEN_SHORT    = 11'h03c;

   // gap timing: least times, rounded up to whole cycles
   localparam int         PST_CLK_NS        = 10;
   localparam int         PST_IFG_LONG_NS   = 9600;
   localparam int         PST_IFG_SHORT_NS  = 96;
   localparam int         PST_IFG_LONG_CYC  = (PST_IFG_LONG_NS + PST_CLK_NS - 1) / PST_CLK_NS;
   localparam int         PST_IFG_SHORT_CYC = (PST_IFG_SHORT_NS + PST_CLK_NS - 1) / PST_CLK_NS;

   // prbs9 seed and buffer depth
   localparam logic [8:0] PST_PRBS_SEED     = 9'h1ff;
   localparam int         PST_FIFO_DEPTH    = 8;

   // byte of a generated frame on its way to the transmit path
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } pst_byte_t;

   // one decoded management write
   typedef struct packed {
      logic [4:0]  addr;
      logic [15:0] data;
   } pst_wr_t;

   // frame count code to number of frames, zero means endless
   function automatic logic [23:0] pst_frames(input logic [2:0] code);
      case (code)
         3'h1:    pst_frames = 24'h00_0001;
         3'h2:    pst_frames = 24'h00_000a;
         3'h3:    pst_frames = 24'h00_0064;
         3'h4:    pst_frames = 24'h00_03e8;
         3'h5:    pst_frames = 24'h00_2710;
         3'h6:    pst_frames = 24'h01_86a0;
         3'h7:    pst_frames = 24'h98_9680;
         default: pst_frames = 24'h00_0000;
      endcase
   endfunction

endpackage

// >>> pst_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pst_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 8
) (
   input  wire logic         clk_i,     // core clock
   input  wire logic         rst_i,     // sync reset, high
   input  wire logic [W-1:0] in_data_i, // write data
   input  wire logic         in_valid_i,// write request
   output logic              in_ready_o,// not full
   output logic [W-1:0]      out_data_o,// head word
   output logic              out_valid_o,// not empty
   input  wire logic         out_ready_i // drain strobe
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         push;
   logic         pop;

   // full when pointers differ only in the wrap bit
   assign in_ready_o  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid_o = (wr_q != rd_q);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_q[rd_q[AW-1:0]];

   // storage, no reset needed on data
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   // pointers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> pst_top.sv
// event-clear register and packet self-test logic behind the serial management port
// Function
// (R1) Writing 1 to event-clear bits 15..3 drops the matching latched flag and the bit reads back 0.
// (R2) Event-clear bits 2..0 are reserved, written as zero by software and read back as zero.
// (R3) A 32-bit receive count is kept and one 16-bit half of it shows in the count window.
// (R4) Config a bit 15 set counts received frames with crc errors, clear counts all frames.
// (R5) Writing 1 to config a bit 14 zeroes the whole 32-bit count and the bit reads back 0.
// (R6) Config a bit 13 makes generated frames 1514 bytes when set and 60 bytes when clear.
// (R7) Config a bit 12 makes the gap between generated frames 9.6 us when set, 0.096 us when clear; the code gives 0.1 us (10 cycles) when clear.
// (R8) Config a bit 11 starts transmit self-test and clears itself after the chosen frames are sent.
// (R9) Half-select 0 shows count bits 15..0 and 1 shows bits 31..16.
// (R10) The receive count advances only while its enable is set and never touches reception.
// (R11) The 3-bit frame count code gives endless for 000, one frame for 001, up to ten million.
// (R12) Frames carry the 8-bit user pattern when user content is chosen, else a prbs9 sequence.
// (R13) The interrupt output falls as soon as no set and unmasked flag remains.
// (R14) All writable bits of the event-clear and self-test config registers reset to zero.
`timescale 1ns/1ps
`default_nettype none
module pst_top
   import pst_pkg::*;
(
   input  wire logic         clk_i,         // core clock, 100 MHz
   input  wire logic         rst_i,         // sync reset, high
   input  wire logic         mdc_i,         // management clock pin
   input  wire logic         mdio_i,        // management data pin in
   output logic              mdio_o,        // management data pin out
   output logic              mdio_oe_o,     // high while driving mdio
   input  wire logic [4:0]   phy_addr_i,    // port address to answer on
   input  wire logic [15:3]  event_i,       // event pulses setting flags
   input  wire logic [15:3]  event_mask_i,  // flag enables toward int
   output logic [15:3]       event_flag_o,  // latched event flags
   output logic              int_o,         // any unmasked flag, high
   input  wire logic         rx_frame_end_i,// received frame finished
   input  wire logic         rx_crc_err_i,  // that frame had bad crc
   output logic [7:0]        tx_data_o,     // test frame byte
   output logic              tx_last_o,     // last byte of frame
   output logic              tx_valid_o,    // byte available
   input  wire logic         tx_ready_i,    // transmit path takes byte
   output logic              tx_busy_o,     // transmit self-test running
   output logic              link_sel_o     // led link-only select
);

   typedef enum logic [1:0] {
      MS_PRE  = 2'b00,
      MS_HDR  = 2'b01,
      MS_TA   = 2'b10,
      MS_DATA = 2'b11
   } pst_ms_t;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_FRAME = 2'b01,
      TX_GAP   = 2'b10
   } pst_tx_t;

   logic [2:0]  mdc_s_q;
   logic [2:0]  mdio_s_q;
   logic        mdc_st_q;
   logic        mdio_st_q;
   logic        mdc_rise;
   logic        bit_w;

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mdc_s_q   <= 3'h0;
         mdio_s_q  <= 3'h7;
         mdc_st_q  <= 1'b0;
         mdio_st_q <= 1'b1;
      end else begin
         mdc_s_q  <= {mdc_s_q[1:0], mdc_i};
         mdio_s_q <= {mdio_s_q[1:0], mdio_i};
         if (mdc_s_q[1] == mdc_s_q[2]) begin
            mdc_st_q <= mdc_s_q[2];
         end
         if (mdio_s_q[1] == mdio_s_q[2]) begin
            mdio_st_q <= mdio_s_q[2];
         end
      end
   end

   assign mdc_rise = mdc_s_q[1] && mdc_s_q[2] && !mdc_st_q;
   assign bit_w    = (mdio_s_q[1] == mdio_s_q[2]) ? mdio_s_q[2] : mdio_st_q;

   pst_ms_t     ms_q;
   logic [5:0]  pre_q;
   logic [4:0]  cnt_q;
   logic [11:0] hdr_q;
   logic [15:0] sh_q;
   logic        rd_q;
   logic        wr_stb_q;
   pst_wr_t     wr_q;
   logic        mdio_o_q;
   logic        mdio_oe_q;
   logic [15:0] rd_data;
   logic        hit;

   logic [15:3] flag_q;
   logic        cnt_type_q;
   logic        long_len_q;
   logic        long_ifg_q;
   logic        tx_run_q;
   logic        prbs_sel_q;
   logic [7:0]  pattern_q;
   logic        rx_en_q;
   logic        half_q;
   logic [2:0]  cnt_code_q;
   logic        link_sel_q;
   logic [31:0] rx_cnt_q;
   logic        tx_done;

   // address match on the last header bit; reads only for our port
   assign hit = (hdr_q[9:5] == phy_addr_i);

   // read mux; reserved bits and the self-clearing bits other than the run bit read as zero, the run bit reads its state
   always_comb begin
      rd_data = 16'h0000;
      case (hdr_q[4:0])
         PST_REG_EVT_CLR: rd_data = 16'h0000; // [R1] [R2]
         PST_REG_CNT_WIN: rd_data = half_q ? rx_cnt_q[31:16] : rx_cnt_q[15:0]; // [R3] [R9]
         PST_REG_CFG_A: begin
            rd_data[PST_A_CNT_TYPE]   = cnt_type_q;
            rd_data[PST_A_LONG_LEN]   = long_len_q;
            rd_data[PST_A_LONG_IFG]   = long_ifg_q;
            rd_data[PST_A_TX_EN]      = tx_run_q;
            rd_data[PST_A_PRBS]       = prbs_sel_q;
            rd_data[PST_A_PAT_HI:0]   = pattern_q;
         end
         PST_REG_CFG_B: begin
            rd_data[PST_B_RX_EN]      = rx_en_q;
            rd_data[PST_B_HALF]       = half_q;
            rd_data[PST_B_CNT_HI:PST_B_CNT_LO] = cnt_code_q;
            rd_data[PST_B_LINK_SEL]   = link_sel_q;
         end
         default: rd_data = 16'h0000;
      endcase
   end

   // frame walk on each synced mdc rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_q      <= MS_PRE;
         pre_q     <= 6'h00;
         cnt_q     <= 5'h00;
         hdr_q     <= 12'h000;
         sh_q      <= 16'h0000;
         rd_q      <= 1'b0;
         wr_stb_q  <= 1'b0;
         wr_q      <= '0;
         mdio_o_q  <= 1'b1;
         mdio_oe_q <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         if (mdc_rise) begin
            case (ms_q)
               MS_PRE: begin
                  // count ones, then a 0 followed by the start 1
                  if (bit_w) begin
                     if (pre_q == 6'(PST_PRE_BITS + 1)) begin
                        ms_q  <= MS_HDR;
                        cnt_q <= 5'h00;
                     end else if (pre_q < 6'(PST_PRE_BITS)) begin
                        pre_q <= pre_q + 6'h01;
                     end
                  end else if (pre_q == 6'(PST_PRE_BITS)) begin
                     pre_q <= 6'(PST_PRE_BITS + 1);
                  end else begin
                     pre_q <= 6'h00;
                  end
               end
               MS_HDR: begin
                  hdr_q <= {hdr_q[10:0], bit_w};
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'(PST_HDR_BITS - 1)) begin
                     ms_q  <= MS_TA;
                     cnt_q <= 5'h00;
                  end
               end
               MS_TA: begin
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'h00) begin
                     rd_q <= (hdr_q[11:10] == PST_OP_READ) && hit;
                     if ((hdr_q[11:10] == PST_OP_READ) && hit) begin
                        mdio_oe_q <= 1'b1;
                        mdio_o_q  <= 1'b0;
                     end
                  end else begin
                     ms_q     <= MS_DATA;
                     cnt_q    <= 5'h00;
                     sh_q     <= {rd_data[14:0], 1'b0};
                     mdio_o_q <= rd_data[15];
                  end
               end
               MS_DATA: begin
                  cnt_q    <= cnt_q + 5'h01;
                  mdio_o_q <= sh_q[15];
                  sh_q     <= rd_q ? {sh_q[14:0], 1'b0} : {sh_q[14:0], bit_w};
                  if (cnt_q == 5'(PST_DATA_BITS - 1)) begin
                     ms_q      <= MS_PRE;
                     pre_q     <= 6'h00;
                     mdio_oe_q <= 1'b0;
                     mdio_o_q  <= 1'b1;
                     rd_q      <= 1'b0;
                     if (!rd_q && (hdr_q[11:10] == PST_OP_WRITE) && hit) begin
                        wr_stb_q  <= 1'b1;
                        wr_q.addr <= hdr_q[4:0];
                        wr_q.data <= {sh_q[14:0], bit_w};
                     end
                  end
               end
               default: ms_q <= MS_PRE;
            endcase
         end
      end
   end

   assign mdio_o    = mdio_o_q;
   assign mdio_oe_o = mdio_oe_q;

   // latched flags; a new event beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= '0;
      end else if (wr_stb_q && (wr_q.addr == PST_REG_EVT_CLR)) begin
         flag_q <= (flag_q & ~wr_q.data[PST_EVT_HI:PST_EVT_LO]) | event_i; // [R1]
      end else begin
         flag_q <= flag_q | event_i;
      end
   end

   assign event_flag_o = flag_q;
   // combinational so it drops with the flag in the clear cycle
   assign int_o        = |(flag_q & event_mask_i); // [R13]

   // config registers; self-clearing bits other than the run bit are strobes, not storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_type_q <= 1'b0; // [R14]
         long_len_q <= 1'b0;
         long_ifg_q <= 1'b0;
         prbs_sel_q <= 1'b0;
         pattern_q  <= 8'h00;
         rx_en_q    <= 1'b0;
         half_q     <= 1'b0;
         cnt_code_q <= 3'h0;
         link_sel_q <= 1'b0;
      end else if (wr_stb_q) begin
         if (wr_q.addr == PST_REG_CFG_A) begin
            cnt_type_q <= wr_q.data[PST_A_CNT_TYPE];
            long_len_q <= wr_q.data[PST_A_LONG_LEN];
            long_ifg_q <= wr_q.data[PST_A_LONG_IFG];
            prbs_sel_q <= wr_q.data[PST_A_PRBS];
            pattern_q  <= wr_q.data[PST_A_PAT_HI:0];
         end
         if (wr_q.addr == PST_REG_CFG_B) begin
            rx_en_q    <= wr_q.data[PST_B_RX_EN];
            half_q     <= wr_q.data[PST_B_HALF];
            cnt_code_q <= wr_q.data[PST_B_CNT_HI:PST_B_CNT_LO];
            link_sel_q <= wr_q.data[PST_B_LINK_SEL];
         end
      end
   end

   assign link_sel_o = link_sel_q;

   // run bit: write 1 starts, write 0 stops after the current frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_run_q <= 1'b0; // [R14]
      end else if (wr_stb_q && (wr_q.addr == PST_REG_CFG_A)) begin
         tx_run_q <= wr_q.data[PST_A_TX_EN]; // [R8]
      end else if (tx_done) begin
         tx_run_q <= 1'b0; // [R8]
      end
   end

   // receive count; only watches frame-end strobes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_cnt_q <= 32'h0000_0000;
      end else if (wr_stb_q && (wr_q.addr == PST_REG_CFG_A) && wr_q.data[PST_A_CNT_CLR]) begin
         rx_cnt_q <= 32'h0000_0000; // [R5]
      end else if (rx_en_q && rx_frame_end_i && (!cnt_type_q || rx_crc_err_i)) begin // [R10] [R4]
         rx_cnt_q <= rx_cnt_q + 32'h0000_0001;
      end
   end

   pst_tx_t     tx_q;
   logic [10:0] byte_q;
   logic [10:0] gap_q;
   logic [23:0] sent_q;
   logic [8:0]  lfsr_q;
   logic [10:0] frame_len;
   logic [10:0] gap_len;
   logic [23:0] target;
   logic        push_ready;
   logic        push_valid;
   pst_byte_t   push_byte;
   pst_byte_t   pop_byte;

   assign frame_len = long_len_q ? PST_LEN_LONG : PST_LEN_SHORT; // [R6]
   assign gap_len   = long_ifg_q ? 11'(PST_IFG_LONG_CYC) : 11'(PST_IFG_SHORT_CYC); // [R7]
   assign target    = pst_frames(cnt_code_q); // [R11]
   assign push_valid = (tx_q == TX_FRAME);
   assign push_byte.data = prbs_sel_q ? lfsr_q[7:0] : pattern_q; // [R12]
   assign push_byte.last = (byte_q == frame_len - 11'h001);
   // done after the last byte of the final counted frame is queued
   assign tx_done = push_valid && push_ready && push_byte.last && (target != 24'h00_0000)
                    && (sent_q + 24'h00_0001 >= target); // [R8] [R11]

   // frame, gap, frame; a full buffer stalls the byte walk
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_q   <= TX_IDLE;
         byte_q <= 11'h000;
         gap_q  <= 11'h000;
         sent_q <= 24'h00_0000;
         lfsr_q <= PST_PRBS_SEED;
      end else begin
         case (tx_q)
            TX_IDLE: begin
               sent_q <= 24'h00_0000;
               byte_q <= 11'h000;
               if (tx_run_q) begin
                  tx_q <= TX_FRAME;
               end
            end
            TX_FRAME: begin
               if (push_ready) begin
                  lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]}; // x^9 + x^5 + 1
                  byte_q <= byte_q + 11'h001;
                  if (push_byte.last) begin
                     byte_q <= 11'h000;
                     gap_q  <= 11'h000;
                     sent_q <= sent_q + 24'h00_0001;
                     tx_q   <= TX_GAP;
                  end
               end
            end
            TX_GAP: begin
               gap_q <= gap_q + 11'h001;
               if (gap_q >= gap_len - 11'h001) begin
                  tx_q <= tx_run_q ? TX_FRAME : TX_IDLE;
               end
            end
            default: tx_q <= TX_IDLE;
         endcase
      end
   end

   assign tx_busy_o = (tx_q != TX_IDLE) || tx_run_q;

   // buffer toward the transmit path
   pst_fifo #(
      .W     ($bits(pst_byte_t)),
      .DEPTH (PST_FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_data_i   (push_byte),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .out_data_o  (pop_byte),
      .out_valid_o (tx_valid_o),
      .out_ready_i (tx_ready_i)
   );

   assign tx_data_o = pop_byte.data;
   assign tx_last_o = pop_byte.last;

endmodule
`default_nettype wire

// >>> pst_sva.sv
// assertion checker for the event-clear and self-test block
`timescale 1ns/1ps
`default_nettype none
module pst_sva
   import pst_pkg::*;
(
   input  wire logic        clk_i,        // core clock
   input  wire logic        rst_i,        // sync reset, high
   input  wire logic        mdio_oe_o,    // mdio drive enable
   input  wire logic [15:3] event_i,      // event pulses
   input  wire logic [15:3] event_mask_i, // flag enables
   input  wire logic [15:3] event_flag_o, // latched flags
   input  wire logic        int_o,        // interrupt out
   input  wire logic [7:0]  tx_data_o,    // test frame byte
   input  wire logic        tx_last_o,    // last byte of frame
   input  wire logic        tx_valid_o,   // byte available
   input  wire logic        tx_ready_i,   // consumer takes byte
   input  wire logic        tx_busy_o     // self-test running
);
   logic [10:0] bcnt_q;                                // bytes of current frame
   wire logic   take = tx_valid_o & tx_ready_i;

   // bytes so far in frame
   always_ff @(posedge clk_i) begin
      if (rst_i || (take && tx_last_o)) bcnt_q <= 11'h000;
      else if (take) bcnt_q <= bcnt_q + 11'h001;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // stalled head byte holds
   sequence s_stall;
      tx_valid_o && !tx_ready_i;
   endsequence
   sequence s_held;
      tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
   endsequence

   a_int_from_flags: assert property (int_o == |(event_flag_o & event_mask_i))
      else $error("int mismatch");
   a_flag_sets: assert property (|event_i |=> (event_flag_o & $past(event_i)) == $past(event_i))
      else $error("flag not latched");
   a_flag_cause: assert property ((event_flag_o & ~$past(event_flag_o) & ~$past(event_i)) == 13'h0000)
      else $error("flag without event");
   a_reset_clean: assert property (disable iff (1'b0)
      rst_i |=> !tx_valid_o && !tx_busy_o && !mdio_oe_o && event_flag_o == 13'h0000)
      else $error("reset state");
   a_frame_len: assert property (take && tx_last_o |-> bcnt_q == 11'h03b || bcnt_q == 11'h5e9)
      else $error("bad frame length");
   a_stall_hold: assert property (s_stall |=> s_held)
      else $error("stalled byte changed");
   a_valid_cause: assert property ($rose(tx_valid_o) |-> $past(tx_busy_o))
      else $error("byte while idle");
   a_busy_output: assert property ($rose(tx_busy_o) |-> ##[1:6] tx_valid_o)
      else $error("no byte after start");
endmodule

bind pst_top pst_sva u_sva (.clk_i, .rst_i, .mdio_oe_o, .event_i, .event_mask_i, .event_flag_o,
   .int_o, .tx_data_o, .tx_last_o, .tx_valid_o, .tx_ready_i, .tx_busy_o);
`default_nettype wire

// >>> pst_mgmt_station.sv
// management station model on mdc and mdio
`timescale 1ns/1ps
`default_nettype none
module pst_mgmt_station
   import pst_pkg::*;
(
   input  wire logic clk_i,     // core clock, paces the bits
   output logic      mdc_o,     // management clock, low until the first frame, high when idle after it
   output logic      mdio_o,    // data driven by the station
   output logic      mdio_oe_o, // high while station drives
   input  wire logic mdio_i     // resolved line, pulled up
);
   // idle: clock still, line released to its pull-up
   initial {mdc_o, mdio_o, mdio_oe_o} = 3'b010;

   // one bit: 5 clk low, 5 high; sample just before the rise
   task automatic bit_io(input logic oe, input logic b, output logic s);
      mdio_oe_o = oe;
      mdio_o = b;
      mdc_o = 1'b0;
      repeat (5) @(posedge clk_i);
      #1 s = mdio_i;
      mdc_o = 1'b1;
      repeat (5) @(posedge clk_i);
      #1;
   endtask

   // one frame with its own preamble; released while reading
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic        s;
      logic [13:0] h;
      logic        w;
      h = {2'b01, op, pa, ra};
      w = (op == PST_OP_WRITE);
      for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_io(1'b1, h[i], s);
      bit_io(w, 1'b1, s);
      bit_io(w, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_io(w, wd[i], s);
         rd[i] = s;
      end
      mdio_oe_o = 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking testbench for the event-clear and self-test block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pst_pkg::*;
   localparam logic [4:0] PA = 5'h03;
   logic        clk_i, rst_i, mdc, st_o, st_oe, d_o, d_oe, rx_end, rx_err, rdy, stall;
   logic        txv, tlast, busy, irq, upat, lsel;
   logic [4:0]  pa;
   logic [7:0]  txd, pat, prev;
   logic [15:3] ev, msk, flg;
   int          errors, n_checks, nb, nfr, nbad, ndiff, gap, gmin, gmax, elen;
   wire logic   line = d_oe ? d_o : (st_oe ? st_o : 1'b1); // pull-up when nobody drives

   pst_top uut (.clk_i, .rst_i, .mdc_i(mdc), .mdio_i(line), .mdio_o(d_o), .mdio_oe_o(d_oe),
      .phy_addr_i(PA), .event_i(ev), .event_mask_i(msk), .event_flag_o(flg), .int_o(irq),
      .rx_frame_end_i(rx_end), .rx_crc_err_i(rx_err), .tx_data_o(txd), .tx_last_o(tlast),
      .tx_valid_o(txv), .tx_ready_i(rdy), .tx_busy_o(busy), .link_sel_o(lsel));
   pst_mgmt_station st (.clk_i, .mdc_o(mdc), .mdio_o(st_o), .mdio_oe_o(st_oe), .mdio_i(line));

   // 100 MHz core clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // consumer, half rate when stalled
   always @(posedge clk_i) rdy <= #1 (!stall || !rdy);

   // frame monitor
   always @(posedge clk_i) begin
      gap++;
      if (txv && rdy) begin
         if (nb == 0 && nfr > 0 && gap > gmax) gmax = gap;
         if (nb == 0 && nfr > 0 && gap < gmin) gmin = gap;
         if (upat && txd !== pat) nbad++;
         if (txd !== prev) ndiff++;
         prev = txd;
         nb++;
         if (tlast) begin
            if (nb != elen) nbad++;
            nfr++;
            nb = 0;
            gap = 0;
         end
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s: %h != %h", $time, m, got, exp);
      end
   endtask

   task automatic final_report;
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] x;
      st.frame(PST_OP_WRITE, pa, ra, d, x);
   endtask

   task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] x;
      st.frame(PST_OP_READ, pa, ra, 16'h0000, x);
      chk(x, exp, "read");
   endtask

   task automatic pulse(input logic e);
      @(posedge clk_i);
      #1 {rx_end, rx_err} = {1'b1, e};
      @(posedge clk_i);
      #1 {rx_end, rx_err} = 2'b00;
   endtask

   // start a run with fresh totals
   task automatic run(input logic [15:0] a, input logic [15:0] b, input int len, input logic u);
      {nfr, nb, nbad, ndiff, gmax} = '0;
      {elen, pat, upat, gmin} = {len, a[7:0], u, 32'd99999};
      wr(PST_REG_CFG_B, b);
      wr(PST_REG_CFG_A, a);
   endtask

   task automatic idle;
      for (int i = 0; i < 20000 && (busy || txv); i++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      #1 chk(16'(busy), 16'h0000, "still busy");
   endtask

   // watchdog
   initial begin
      repeat (80000) @(posedge clk_i);
      errors++;
      $display("[ERR] %0t timeout", $time);
      final_report;
   end

   initial begin
      {rst_i, rx_end, rx_err, stall, rdy, pa} = {4'b1000, 1'b1, PA};
      {ev, msk, prev, gap} = '0;
      repeat (16) @(posedge clk_i);
      #1 rst_i = 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      for (int r = 23; r <= 26; r++) rd(r[4:0], 16'h0000);
      rd(5'h10, 16'h0000);
      chk(16'(lsel), 16'h0000, "link select");
      // wrong port address: no answer and no write
      pa = PA ^ 5'h01;
      rd(PST_REG_CFG_A, 16'hffff);
      wr(PST_REG_CFG_A, 16'h2000);
      pa = PA;
      rd(PST_REG_CFG_A, 16'h0000);
      // latch all flags, drop one, then the rest
      ev = '1;
      msk[5] = 1'b1;
      @(posedge clk_i);
      #1 ev = '0;
      chk({flg, 3'b000}, 16'hfff8, "flags latched");
      chk(16'(irq), 16'h0001, "int raised");
      wr(PST_REG_EVT_CLR, 16'h0020);
      chk({flg, 3'b000}, 16'hffd8, "one flag dropped");
      chk(16'(irq), 16'h0000, "int after clear");
      rd(PST_REG_EVT_CLR, 16'h0000);
      wr(PST_REG_EVT_CLR, 16'hfff8);
      chk({flg, 3'b000}, 16'h0000, "flags dropped");
      // receive count cases
      wr(PST_REG_CFG_B, 16'h8000);
      pulse(1'b0); pulse(1'b1); pulse(1'b0);
      rd(PST_REG_CNT_WIN, 16'h0003);
      wr(PST_REG_CFG_A, 16'h8000);
      pulse(1'b1); pulse(1'b0);
      rd(PST_REG_CNT_WIN, 16'h0004);
      wr(PST_REG_CFG_B, 16'hc000);
      pulse(1'b1);
      rd(PST_REG_CNT_WIN, 16'h0000);
      wr(PST_REG_CFG_B, 16'h0000);
      pulse(1'b1);
      rd(PST_REG_CNT_WIN, 16'h0005);
      wr(PST_REG_CFG_A, 16'hc000);
      rd(PST_REG_CFG_A, 16'h8000);
      rd(PST_REG_CNT_WIN, 16'h0000);
      // one long user frame against a stalling consumer
      stall = 1'b1;
      run(16'h28c3, 16'h0800, 1514, 1'b1);
      idle;
      stall = 1'b0;
      chk(nfr[15:0], 16'h0001, "code 1");
      chk(nbad[15:0], 16'h0000, "long frame");
      rd(PST_REG_CFG_A, 16'h20c3);
      // ten short prbs frames, short then long gap
      run(16'h0c00, 16'h1000, 60, 1'b0);
      idle;
      chk(nfr[15:0], 16'h000a, "code 2");
      chk(16'(gmax < 40), 16'h0001, "short gap");
      run(16'h1c00, 16'h1000, 60, 1'b0);
      idle;
      chk(16'(gmin >= 950), 16'h0001, "long gap");
      chk(16'(ndiff > 300), 16'h0001, "prbs varies");
      chk(nbad[15:0], 16'h0000, "short length");
      // other codes, stopped by hand
      for (int c = 0; c < 8; c++) begin
         if (c == 0 || c > 2) begin
            run(16'h0c00, {2'b00, c[2:0], 11'h000}, 60, 1'b0);
            wr(PST_REG_CFG_A, 16'h0400);
            idle;
            chk(16'(nfr > 1), 16'h0001, "long code");
         end
      end
      final_report;
   end
endmodule
`default_nettype wire
